// [rtl/sfc_pkg.sv]
// Shared constants and types for the SPI frame checker with daisy chain support.
// Assumes a single core clock; link pins are sampled, never used as clocks.
package sfc_pkg;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************
  localparam int FRAME_BITS  = 24;
  localparam int BYTE_BITS   = 8;
  localparam int RESP_W      = 16;
  localparam int ADDR_W      = 5;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // Address byte fields
  // ****************************************************************
  localparam int ADR_MARK_BIT = 7;
  localparam int ADR_LAST_BIT = 6;
  localparam int ADR_REG_HI   = 5;
  localparam int ADR_REG_LO   = 1;
  localparam int ADR_OP_BIT   = 0;

  localparam logic [ADDR_W-1:0] ID_REG_ADDR = 5'h1F;

  // ****************************************************************
  // Status byte and reset values
  // ****************************************************************
  localparam int          STS_ERR_BIT   = 1;
  localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0]  SYNC_RST_VAL  = 3'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT8, ST_PASS, ST_RESP} sfc_state_e;

endpackage

// [rtl/sfc_sync.sv]
// Two-stage synchroniser for pins from outside the core clock domain.
// Assumes the reset value is a constant chosen to match the idle pin level.
`timescale 1ns/1ps
`default_nettype none

module sfc_sync #(
  parameter int             W       = 3,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  if (W < 1)
  begin : g_chk
    $error("sfc_sync: width must be at least one");
  end

  // ****************************************************************
  // Only the second stage is visible outside.
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule
`default_nettype wire

// [rtl/sfc_frame_checker.sv]
// SPI slave front end: frame checking, protocol error flag, daisy chain shifting.
// Assumes the register bank answers i_resp_data, i_impl_mask decisions combinationally.
//
// What this block does
// - An error in one frame shows as the error flag in the next frame.
// - Nonzero pulse count below 24, or above 24 and not a multiple of 8, errs.
// - A command to an unimplemented register address is an error.
// - Serial clock high at either chip select edge is a polarity error.
// - A clocked frame without any address byte or without a final one errs.
// - Gapped address bytes err and drive serial out low from the gap byte to the select rise unless the clock was high at the select fall.
// - A clear command to the identification register is an error.
// - A half-bridge on several enabled PWM channels holds the error flag.
// - Commands enabling a conflicted half-bridge are discarded.
// - In fail-safe, writes other than kick or exit sequence are refused and err.
// - In normal mode one good frame clears the error flag.
// - An error flagged in fail-safe holds until normal mode returns.
// - Frames above 24 bits are accepted when whole bytes with proper addresses.
// - Shift 8 bits until the first address byte, which is our own.
// - After our address, copy serial in to serial out until the final address.
// - Shift out the response high byte, then the low byte.
// - After the final address byte act as a 16-bit shift register.
// - Before the first clock rise, serial out shows OR of the fault flags and serial in.
// - Status bytes then responses emerge in reverse device order.
// - Sample on clock fall, drive on clock rise, clock idles low, MSB first.
// - Write and clear commands are applied at the chip select rise.
// - The first eight clocks shift out the status byte with the error flag.
`timescale 1ns/1ps
`default_nettype none

module sfc_frame_checker #(
  parameter int CNT_W = 10
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_sclk,
  input  wire logic                       i_chip_select_low_n,
  input  wire logic                       i_serial_in,
  output logic                            o_serial_out,
  output logic                            o_serial_out_oe_n,
  input  wire logic                       i_global_fault_flag,
  input  wire logic [sfc_pkg::BYTE_BITS-1:0] i_chip_status_byte,
  input  wire logic [31:0]                i_impl_mask,
  input  wire logic [sfc_pkg::RESP_W-1:0] i_resp_data,
  input  wire logic                       i_fail_safe,
  input  wire logic                       i_fs_cmd_ok,
  input  wire logic                       i_bridge_channel_conflict_flag,
  input  wire logic                       i_enables_conflicted_bridge,
  output logic [sfc_pkg::ADDR_W-1:0]      o_addr,
  output logic                            o_operation_select_bit,
  output logic [sfc_pkg::RESP_W-1:0]      o_cmd_data,
  output logic                            o_cmd_valid,
  output logic                            o_frame_done,
  output logic                            o_protocol_error_flag
);
  import sfc_pkg::*;

  if (CNT_W < 6)
  begin : g_chk
    $error("sfc_frame_checker: counter too narrow to judge frame length");
  end

  // ****************************************************************
  // Pin sampling and edge detection
  // ****************************************************************
  logic sclk_s;
  logic csn_s;
  logic sdi_s;
  logic sclk_q;
  logic csn_q;

  sfc_sync #(.W(3), .RST_VAL(SYNC_RST_VAL)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_d        ({i_sclk, i_chip_select_low_n, i_serial_in}),
    .o_q        ({sclk_s, csn_s, sdi_s})
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      csn_q  <= csn_s;
    end
  end

  logic active;
  logic sclk_fall;
  logic sclk_rise;
  logic csn_fall;
  logic csn_rise;

  assign active    = ~csn_s;
  assign sclk_fall = sclk_q & ~sclk_s & active;
  assign sclk_rise = ~sclk_q & sclk_s & active;
  assign csn_fall  = csn_q & ~csn_s;
  assign csn_rise  = ~csn_q & csn_s;

  function automatic logic is_addr(input logic [BYTE_BITS-1:0] b);
    is_addr = b[ADR_MARK_BIT];
  endfunction

  function automatic logic is_final(input logic [BYTE_BITS-1:0] b);
    is_final = b[ADR_MARK_BIT] & b[ADR_LAST_BIT];
  endfunction

  // ****************************************************************
  // Pulse counter and byte framing
  // ****************************************************************
  logic [CNT_W-1:0]     cnt_r;
  logic [RESP_W-1:0]    sh_r;
  logic [BYTE_BITS-1:0] byte_in;
  logic                 byte_done;

  assign byte_in   = {sh_r[BYTE_BITS-2:0], sdi_s};
  assign byte_done = sclk_fall & (cnt_r[2:0] == BYTE_LAST_BIT);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_r <= '0;
    else if (csn_fall)
      cnt_r <= '0;
    else if (sclk_fall && !(&cnt_r))
      cnt_r <= cnt_r + 1'b1;
  end

  // ****************************************************************
  // Chain state machine
  // ****************************************************************
  sfc_state_e st_r;
  logic       gap_r;
  logic       load_pend_r;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= ST_IDLE;
    else if (csn_fall)
      st_r <= ST_SHIFT8;
    else if (csn_rise)
      st_r <= ST_IDLE;
    else if (byte_done)
    begin
      case (st_r)
        ST_SHIFT8:
          if (is_addr(byte_in))
            st_r <= is_final(byte_in) ? ST_RESP : ST_PASS;
        ST_PASS:
          if (is_final(byte_in))
            st_r <= ST_RESP;
        default:
          st_r <= st_r;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      gap_r <= 1'b0;
    else if (csn_fall)
      gap_r <= 1'b0;
    else if (byte_done && st_r == ST_PASS && !is_addr(byte_in))
      gap_r <= 1'b1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_addr                 <= '0;
      o_operation_select_bit <= 1'b0;
    end
    else if (csn_fall)
      o_operation_select_bit <= 1'b0;
    else if (byte_done && st_r == ST_SHIFT8 && is_addr(byte_in))
    begin
      o_addr                 <= byte_in[ADR_REG_HI:ADR_REG_LO];
      o_operation_select_bit <= byte_in[ADR_OP_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      load_pend_r <= 1'b0;
    else
      load_pend_r <= byte_done && st_r != ST_RESP && st_r != ST_IDLE && is_final(byte_in);
  end

  // ****************************************************************
  // Shift register: status byte, then response and received data
  // ****************************************************************
  logic                 flag_r;
  logic [BYTE_BITS-1:0] status;

  always_comb
  begin
    status               = i_chip_status_byte;
    status[STS_ERR_BIT]  = flag_r;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sh_r <= '0;
    else if (csn_fall)
      sh_r <= {{(RESP_W-BYTE_BITS){1'b0}}, status};
    else if (load_pend_r)
      sh_r <= i_resp_data;
    else if (sclk_fall)
      sh_r <= {sh_r[RESP_W-2:0], sdi_s};
  end

  assign o_cmd_data = sh_r;

  // ****************************************************************
  // Serial output
  // ****************************************************************
  logic first_rise_r;
  logic pol_fall_r;
  logic sdo_r;
  logic own_fault;

  assign own_fault = i_global_fault_flag | flag_r;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      first_rise_r <= 1'b0;
      pol_fall_r   <= 1'b0;
    end
    else if (csn_fall)
    begin
      first_rise_r <= 1'b1;
      pol_fall_r   <= sclk_s;
    end
    else if (sclk_rise)
      first_rise_r <= 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sdo_r <= 1'b0;
    else if (!active)
      sdo_r <= 1'b0;
    else if (gap_r && !pol_fall_r)
      sdo_r <= 1'b0;
    else if (st_r == ST_PASS)
      sdo_r <= sdi_s;
    else if (sclk_rise)
      sdo_r <= (st_r == ST_RESP) ? sh_r[RESP_W-1] : sh_r[BYTE_BITS-1];
    else if (first_rise_r)
      sdo_r <= own_fault | sdi_s;
  end

  assign o_serial_out      = sdo_r;
  assign o_serial_out_oe_n = csn_s;

  // ****************************************************************
  // Frame judgement at chip select rise
  // ****************************************************************
  logic len_err;
  logic pol_err;
  logic addr_err;
  logic cmd_err;
  logic frame_err;
  logic good;
  logic perr_r;
  logic fs_hold_r;

  assign len_err   = (cnt_r != '0 && cnt_r < CNT_W'(FRAME_BITS))
                   || (cnt_r > CNT_W'(FRAME_BITS) && cnt_r[2:0] != 3'h0);
  assign pol_err   = pol_fall_r | sclk_s;
  assign addr_err  = (cnt_r != '0 && st_r != ST_RESP) | gap_r;
  assign cmd_err   = (st_r == ST_RESP)
                   && (!i_impl_mask[o_addr]
                   || (o_operation_select_bit && o_addr == ID_REG_ADDR)
                   || (o_operation_select_bit && i_fail_safe && !i_fs_cmd_ok));
  assign frame_err = len_err | pol_err | addr_err | cmd_err;
  assign good      = csn_rise && !frame_err && st_r == ST_RESP;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      perr_r <= 1'b0;
    else if (csn_rise && frame_err)
      perr_r <= 1'b1;
    else if (good && !i_fail_safe && !fs_hold_r)
      perr_r <= 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fs_hold_r <= 1'b0;
    else if (csn_rise && frame_err && i_fail_safe)
      fs_hold_r <= 1'b1;
    else if (!i_fail_safe)
      fs_hold_r <= 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flag_r <= 1'b0;
    else
      flag_r <= perr_r | i_bridge_channel_conflict_flag;
  end

  assign o_protocol_error_flag = flag_r;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cmd_valid  <= 1'b0;
      o_frame_done <= 1'b0;
    end
    else
    begin
      o_cmd_valid  <= good && o_operation_select_bit && !i_enables_conflicted_bridge;
      o_frame_done <= csn_rise;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_err_next;
    csn_rise && frame_err |-> ##2 status[STS_ERR_BIT];
  endproperty
  property p_len;
    csn_rise && cnt_r != '0 && cnt_r < CNT_W'(FRAME_BITS) |=> perr_r;
  endproperty
  property p_unimpl;
    csn_rise && st_r == ST_RESP && !i_impl_mask[o_addr] |=> perr_r && !o_cmd_valid;
  endproperty
  property p_pol;
    csn_rise && sclk_s |=> perr_r;
  endproperty
  property p_noaddr;
    csn_rise && cnt_r != '0 && st_r != ST_RESP |=> perr_r && !o_cmd_valid;
  endproperty
  property p_gap;
    gap_r && !pol_fall_r && active |=> !o_serial_out;
  endproperty
  property p_id;
    csn_rise && st_r == ST_RESP && o_operation_select_bit && o_addr == ID_REG_ADDR |=> perr_r && !o_cmd_valid;
  endproperty
  property p_conflict;
    i_bridge_channel_conflict_flag |=> o_protocol_error_flag;
  endproperty
  property p_discard;
    csn_rise && i_enables_conflicted_bridge |=> !o_cmd_valid;
  endproperty
  property p_fs;
    csn_rise && st_r == ST_RESP && o_operation_select_bit && i_fail_safe && !i_fs_cmd_ok |=> perr_r && !o_cmd_valid;
  endproperty
  property p_clear;
    good && !i_fail_safe && !fs_hold_r |=> !perr_r;
  endproperty
  property p_hold;
    fs_hold_r && i_fail_safe |=> perr_r;
  endproperty
  property p_apply;
    o_cmd_valid |-> $past(csn_rise) && $past(st_r) == ST_RESP;
  endproperty
  property p_status;
    csn_fall |=> sh_r[STS_ERR_BIT] == $past(flag_r);
  endproperty

  a_err_next: assert property (p_err_next) else $error("error flag missing in next status byte");
  a_len:      assert property (p_len) else $error("short frame not flagged");
  a_unimpl:   assert property (p_unimpl) else $error("unimplemented address not flagged");
  a_pol:      assert property (p_pol) else $error("clock polarity error not flagged");
  a_noaddr:   assert property (p_noaddr) else $error("missing address byte not flagged");
  a_gap:      assert property (p_gap) else $error("serial out not forced low after gap");
  a_id:       assert property (p_id) else $error("clear to identification register accepted");
  a_conflict: assert property (p_conflict) else $error("bridge conflict not shown on flag");
  a_discard:  assert property (p_discard) else $error("conflicting enable command applied");
  a_fs:       assert property (p_fs) else $error("fail-safe write not refused");
  a_clear:    assert property (p_clear) else $error("good frame did not clear flag");
  a_hold:     assert property (p_hold) else $error("fail-safe error released early");
  a_apply:    assert property (p_apply) else $error("command applied outside chip select rise");
  a_status:   assert property (p_status) else $error("status byte lacks error flag");

  c_single:  cover property (good && cnt_r == CNT_W'(FRAME_BITS));
  c_chain:   cover property (good && cnt_r > CNT_W'(FRAME_BITS));
  c_gap:     cover property (csn_rise && gap_r);
  c_cmd:     cover property (o_cmd_valid);

endmodule
`default_nettype wire

// [bench/sfc_spi_master.sv]
// Behavioural SPI master that drives the link pins of the frame checker.
// Assumes a 100 MHz core clock; the serial clock period is 8 core cycles.
`timescale 1ns/1ps
`default_nettype none

module sfc_spi_master (
  input  wire logic i_core_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n,
  output logic      o_sclk,
  output logic      o_csn,
  output logic      o_sdi
);
  logic [63:0] rx;
  logic        flt;
  logic        oe_seen;

  initial
  begin
    o_sclk = 1'h0;
    o_csn  = 1'h1;
    o_sdi  = 1'h0;
  end

  // ********************
  // Frame transfer
  // ********************
  // Sends the low n bits of tx MSB first; pol keeps the serial clock high across the select rise.
  task automatic frame(input int n, input logic [63:0] tx, input bit pol);
    rx = '0;
    @(posedge i_core_clk) o_csn <= 1'h0;
    repeat (5) @(posedge i_core_clk);
    flt = i_sdo;
    oe_seen = i_sdo_oe_n;
    repeat (2) @(posedge i_core_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sclk <= 1'h1;
      o_sdi  <= tx[i];
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'h0;
      repeat (2) @(posedge i_core_clk);
      rx[i] = i_sdo;
      repeat (2) @(posedge i_core_clk);
    end
    repeat (4) @(posedge i_core_clk);
    if (pol)
    begin
      o_sclk <= 1'h1;
      repeat (4) @(posedge i_core_clk);
    end
    o_csn <= 1'h1;
    o_sdi <= 1'h0;
    repeat (4) @(posedge i_core_clk);
    o_sclk <= 1'h0;
    repeat (8) @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// [bench/sfc_frame_checker_tb.sv]
// Self-checking bench for the SPI frame checker: single frames, chain frames, error cases.
// Assumes sfc_spi_master drives the link pins; all other inputs come from here.
`timescale 1ns/1ps
`default_nettype none

module sfc_frame_checker_tb;
  import sfc_pkg::*;

  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        chip_select_low;
  logic        serial_in;
  logic        sdo;
  logic        oe_n;
  logic        gff;
  logic [7:0]  sts;
  logic [31:0] mask;
  logic [15:0] resp;
  logic        fs;
  logic        fs_ok;
  logic        cfl;
  logic        encf;
  logic [4:0]  addr;
  logic        op;
  logic [15:0] cdata;
  logic        cvalid;
  logic        fdone;
  logic        perr;
  logic [21:0] pcmd;
  int          npulse;
  int          nframes;
  int          fails;
  int          checks_done;

  sfc_frame_checker dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_chip_select_low_n(chip_select_low), .i_serial_in(serial_in),
    .o_serial_out(sdo), .o_serial_out_oe_n(oe_n), .i_global_fault_flag(gff), .i_chip_status_byte(sts),
    .i_impl_mask(mask), .i_resp_data(resp), .i_fail_safe(fs), .i_fs_cmd_ok(fs_ok),
    .i_bridge_channel_conflict_flag(cfl), .i_enables_conflicted_bridge(encf), .o_addr(addr),
    .o_operation_select_bit(op), .o_cmd_data(cdata), .o_cmd_valid(cvalid), .o_frame_done(fdone),
    .o_protocol_error_flag(perr));

  sfc_spi_master m (.i_core_clk(clk), .i_sdo(sdo), .i_sdo_oe_n(oe_n), .o_sclk(sclk), .o_csn(chip_select_low), .o_sdi(serial_in));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Records every applied command and every frame end.
  always @(posedge clk)
  begin
    if (cvalid === 1'h1)
    begin
      npulse++;
      pcmd = {addr, op, cdata};
    end
    if (fdone === 1'h1)
      nframes++;
  end

  // ********************
  // Checking and verdict
  // ********************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic good(input logic f_in, input logic f_out, input int pulse);
    int p;
    int fr;
    p = npulse;
    fr = nframes;
    m.frame(24, 64'hC7_1234, 1'h0);
    check(m.rx[23:0], {sts[7:2], f_in, sts[0], resp}, "status and response");
    check(m.flt, gff | f_in, "fault flag before first clock");
    check({m.oe_seen, oe_n}, 2'h1, "output enable");
    check(perr, f_out, "error flag after frame");
    check(64'(npulse - p), 64'(pulse), "command pulses");
    check(64'(nframes - fr), 64'h1, "frame end pulse");
    if (pulse == 1)
      check(pcmd, {5'h03, 1'h1, 16'h1234}, "applied command");
  endtask

  task automatic err_case(input int n, input logic [63:0] tx, input logic [31:0] mk, input bit pol);
    int p;
    p = npulse;
    mask <= mk;
    m.frame(n, tx, pol);
    check(perr, 1'h1, "flag after faulty frame");
    check(64'(npulse - p), 64'h0, "command from faulty frame");
    mask <= 32'hFFFF_FFFF;
    good(1'h1, 1'h0, 1);
  endtask

  task automatic t_basic();
    good(1'h0, 1'h0, 1);
    gff <= 1'h0;
    m.frame(0, 64'h0, 1'h0);
    check({m.flt, perr}, 2'h0, "zero clock frame");
  endtask

  task automatic t_errors();
    err_case(16, 64'hC712, 32'hFFFF_FFFF, 1'h0);
    err_case(23, 64'h63_891A, 32'hFFFF_FFFF, 1'h0);
    err_case(28, 64'hC71_2345, 32'hFFFF_FFFF, 1'h0);
    err_case(24, 64'hC5_1234, 32'hFFFF_FFFB, 1'h0);
    err_case(24, 64'hFF_0000, 32'hFFFF_FFFF, 1'h0);
    err_case(24, 64'h87_1234, 32'hFFFF_FFFF, 1'h0);
    err_case(24, 64'h07_1234, 32'hFFFF_FFFF, 1'h0);
    err_case(24, 64'hC7_1234, 32'hFFFF_FFFF, 1'h1);
  endtask

  task automatic t_chain();
    m.frame(48, 64'h85C9_5A5A_C3C3, 1'h0);
    check(m.rx[47:0], {sts[7:2], 1'h0, sts[0], 8'hC9, resp, 16'h5A5A}, "chain out");
    check({pcmd, perr}, {5'h02, 1'h1, 16'hC3C3, 1'h0}, "chain command");
  endtask

  task automatic t_gap();
    m.frame(40, 64'h85_12C9_5A5A, 1'h0);
    check({m.rx[15:0], perr}, 17'h1, "output and flag after gap");
    good(1'h1, 1'h0, 1);
  endtask

  task automatic t_failsafe();
    fs <= 1'h1;
    good(1'h0, 1'h1, 0);
    fs_ok <= 1'h1;
    good(1'h1, 1'h1, 1);
    fs <= 1'h0;
    fs_ok <= 1'h0;
    good(1'h1, 1'h0, 1);
  endtask

  task automatic t_conflict();
    cfl <= 1'h1;
    encf <= 1'h1;
    repeat (4) @(posedge clk);
    check(perr, 1'h1, "conflict raises flag");
    good(1'h1, 1'h1, 0);
    cfl <= 1'h0;
    encf <= 1'h0;
    repeat (4) @(posedge clk);
    check(perr, 1'h0, "flag released with conflict");
  endtask

  initial
  begin
    rst_n = 1'h0;
    gff = 1'h1;
    sts = 8'h5D;
    mask = 32'hFFFF_FFFF;
    resp = 16'hBEEF;
    fs = 1'h0;
    fs_ok = 1'h0;
    cfl = 1'h0;
    encf = 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    check({oe_n, perr}, 2'h2, "reset values");
    t_basic();
    t_errors();
    t_chain();
    t_gap();
    t_failsafe();
    t_conflict();
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
